//--- logic/pofc_top.sv
// Output stage, fault suppression and module status for four generators.
// Summary of operation
// RULE_01: Period equals programmed ticks between successive zero pulses of a generator.
// RULE_02: A newer period write replaces any still-pending earlier value.
// RULE_03: Mask holds one bit per generator and fault source; set unmasks.
// RULE_04: Raw and masked views of all eight sources are readable.
// RULE_05: Suppressed outputs go inactive during fault; others keep running.
// RULE_06: Extended option drives suppressed output high or low per level bit.
// RULE_07: Without the extended option a suppressed output drives low in fault.
// RULE_08: Level setting has no effect on an output that is not suppressed.
// RULE_09: Invert setting makes an output active low.
// RULE_10: Disabled output holds its inactive state; the code drives it low even when inverted.
// RULE_11: Immediate mode applies enable changes at once.
// RULE_12: Local mode applies at next zero; global needs an armed update first.
// RULE_13: Width readback returns the programmed value, not the active one.
// RULE_14: Four generators each hold an independent period register.
// RULE_15: Masked bit is raw AND mask; interrupt is OR of masked bits.
`timescale 1ns/1ps
`default_nettype none
module pofc_top #(
   parameter bit EXT_FAULT = 1'b1,
   parameter int CNT_W = pofc_pkg::CNT_W
) (
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic [3:0] gen_run_in,
   input wire logic [3:0] period_wr_in,
   input wire logic [CNT_W-1:0] period_in,
   input wire logic [7:0] width_wr_in,
   input wire logic [CNT_W-1:0] width_in,
   input wire logic [2:0] width_sel_in,
   input wire logic [1:0] period_sel_in,
   input wire logic [3:0] gen_event_in,
   input wire logic [3:0] fault_pin_in,
   input wire logic [7:0] irq_mask_in,
   input wire logic status_view_select,
   input wire logic [7:0] suppress_on_fault,
   input wire logic [7:0] fault_level_high,
   input wire logic [7:0] invert_in,
   input wire logic [7:0] output_drive_enable,
   input wire logic [15:0] enable_mode_in,
   input wire logic [3:0] global_update_arm_cmd,
   output logic [7:0] pwm_out,
   output logic [7:0] status_out,
   output logic irq_out,
   output logic [CNT_W-1:0] width_rd_out,
   output logic [CNT_W-1:0] period_rd_out
);
   // Counter widths outside this range cannot be served by the comparators.
   if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
      $error("CNT_W out of range");
   end

   logic [3:0] fault_s1_q;
   logic [3:0] fault_s2_q;
   logic [3:0] zero;
   logic [CNT_W-1:0] cnt [4];
   logic [CNT_W-1:0] prd [4];
   logic [CNT_W-1:0] width_prog_q [8];
   logic [CNT_W-1:0] width_act_q [8];
   logic [7:0] en_act_q;
   logic [3:0] armed_q;
   logic [7:0] pwm_q;
   logic [7:0] status_q;
   logic [7:0] fault_lat_q;
   logic irq_q;
   logic [CNT_W-1:0] wrd_q;
   logic [CNT_W-1:0] prd_q;

   // Fault pins come from outside and pass two flip-flops.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         fault_s1_q <= '0;
         fault_s2_q <= '0;
      end else begin
         fault_s1_q <= fault_pin_in;
         fault_s2_q <= fault_s1_q;
      end
   end

   // Four independent generators, each with its own period register.
   for (genvar g = 0; g < 4; g++) begin : g_gen
      pofc_gen #(.CNT_W(CNT_W)) u_gen ( // RULE_14
         .clock_in(clock_in),
         .srst_in(srst_in),
         .period_wr_in(period_wr_in[g]),
         .period_in(period_in),
         .run_in(gen_run_in[g]),
         .zero_out(zero[g]),
         .count_out(cnt[g]),
         .period_prog_out(prd[g])
      );
   end

   // Raw sources: generator events and synchronised fault levels.
   wire [7:0] raw;
   assign raw[pofc_pkg::SRC_GEN_LSB +: 4] = gen_event_in;
   assign raw[pofc_pkg::SRC_FAULT_LSB +: 4] = fault_s2_q;
   wire [7:0] masked = raw & irq_mask_in; // RULE_03 RULE_15
   wire any_fault = |fault_s2_q;

   // Per output: owning generator, comparator, enable and fault handling.
   logic [7:0] wave;
   logic [7:0] lvl;
   logic [7:0] en_next;
   always_comb begin
      for (int o = 0; o < 8; o++) begin
         wave[o] = ((cnt[o/2] < width_act_q[o]) && gen_run_in[o/2]) ^ invert_in[o]; // RULE_09
         lvl[o] = EXT_FAULT ? fault_level_high[o] : 1'b0; // RULE_06 RULE_07
         en_next[o] = en_act_q[o];
         unique case (enable_mode_in[2*o +: 2])
            pofc_pkg::POFC_UPD_IMMEDIATE: en_next[o] = output_drive_enable[o]; // RULE_11
            pofc_pkg::POFC_UPD_LOCAL: if (zero[o/2]) en_next[o] = output_drive_enable[o];
            pofc_pkg::POFC_UPD_GLOBAL: begin
               if (zero[o/2] && armed_q[o/2]) en_next[o] = output_drive_enable[o]; // RULE_12
            end
            default: en_next[o] = en_act_q[o];
         endcase
      end
   end

   // Widths: programmed copy for readback, active copy loaded at zero.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         for (int o = 0; o < 8; o++) begin
            width_prog_q[o] <= CNT_W'(pofc_pkg::WIDTH_RST);
            width_act_q[o] <= CNT_W'(pofc_pkg::WIDTH_RST);
         end
      end else begin
         for (int o = 0; o < 8; o++) begin
            if (width_wr_in[o]) width_prog_q[o] <= width_in;
            if (zero[o/2]) width_act_q[o] <= width_prog_q[o];
         end
      end
   end

   // Global arm flags; a new arm in the same cycle as a zero wins.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         armed_q <= '0;
      end else begin
         armed_q <= (armed_q & ~zero) | global_update_arm_cmd; // RULE_12
      end
   end

   // Output drive with enable and fault suppression.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         en_act_q <= '0;
         pwm_q <= '0;
      end else begin
         en_act_q <= en_next;
         for (int o = 0; o < 8; o++) begin
            if (any_fault && suppress_on_fault[o]) pwm_q[o] <= lvl[o]; // RULE_05
            else if (!en_act_q[o]) pwm_q[o] <= 1'b0; // RULE_10
            else pwm_q[o] <= wave[o]; // RULE_08
         end
      end
   end

   // Status view, interrupt and readback registers.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         status_q <= '0;
         irq_q <= 1'b0;
         wrd_q <= '0;
         prd_q <= '0;
      end else begin
         status_q <= status_view_select ? masked : raw; // RULE_04
         irq_q <= |masked; // RULE_15
         wrd_q <= width_prog_q[width_sel_in]; // RULE_13
         prd_q <= prd[period_sel_in];
      end
   end

   assign pwm_out = pwm_q;
   assign status_out = status_q;
   assign irq_out = irq_q;
   assign width_rd_out = wrd_q;
   assign period_rd_out = prd_q;

   // Checks.
   property p_irq;
      @(posedge clock_in) disable iff (srst_in) 1'b1 |=> irq_out == $past(|masked);
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch"); // RULE_15
   property p_mview;
      @(posedge clock_in) disable iff (srst_in)
         status_view_select |=> (status_out & ~$past(irq_mask_in)) == 8'h00;
   endproperty
   a_mview: assert property (p_mview) else $error("masked view leak"); // RULE_04
   property p_sup;
      @(posedge clock_in) disable iff (srst_in)
         (any_fault && suppress_on_fault[0]) |=> pwm_out[0] == $past(lvl[0]);
   endproperty
   a_sup: assert property (p_sup) else $error("fault level wrong"); // RULE_05
   property p_dis;
      @(posedge clock_in) disable iff (srst_in)
         (!en_act_q[1] && !(any_fault && suppress_on_fault[1])) |=> !pwm_out[1];
   endproperty
   a_dis: assert property (p_dis) else $error("disabled output active"); // RULE_10
   property p_imm;
      @(posedge clock_in) disable iff (srst_in)
         (enable_mode_in[1:0] == 2'b00) |=> en_act_q[0] == $past(output_drive_enable[0]);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate enable late"); // RULE_11
   property p_glob;
      @(posedge clock_in) disable iff (srst_in)
         (enable_mode_in[1:0] == 2'b10 && !armed_q[0]) |=> $stable(en_act_q[0]);
   endproperty
   a_glob: assert property (p_glob) else $error("global enable unarmed"); // RULE_12
   // A width write to output 0 followed by a cycle with output 0 selected.
   sequence s_wr0_held;
      (width_wr_in[0] && width_sel_in == 3'd0) ##1 (width_sel_in == 3'd0);
   endsequence
   property p_wrd;
      @(posedge clock_in) disable iff (srst_in)
         s_wr0_held |=> width_rd_out == $past(width_in, 2);
   endproperty
   a_wrd: assert property (p_wrd) else $error("width readback wrong"); // RULE_13
   property p_nosup;
      @(posedge clock_in) disable iff (srst_in)
         (!suppress_on_fault[2] && en_act_q[2]) |=> pwm_out[2] == $past(wave[2]);
   endproperty
   a_nosup: assert property (p_nosup) else $error("unsuppressed output changed"); // RULE_08
endmodule : pofc_top
`default_nettype wire

//--- logic/pofc_pkg.sv
// Package of constants and types for the modulator output and fault control block.
`default_nettype none
package pofc_pkg;
   localparam int NUM_GEN = 4;
   localparam int NUM_OUT = 8;
   localparam int NUM_FAULT = 4;
   localparam int NUM_SRC = 8;
   localparam int CNT_W = 16;
   // Bit positions in the eight-bit module status and mask words.
   localparam int SRC_GEN_LSB = 0;
   localparam int SRC_FAULT_LSB = 4;
   // Reset values.
   localparam logic [15:0] PERIOD_RST = 16'hffff;
   localparam logic [15:0] WIDTH_RST = 16'h0000;
   localparam logic [7:0] MASK_RST = 8'h00;
   // Enable-update modes of an output.
   typedef enum logic [1:0] {
      POFC_UPD_IMMEDIATE = 2'b00,
      POFC_UPD_LOCAL = 2'b01,
      POFC_UPD_GLOBAL = 2'b10
   } pofc_upd_t;
endpackage : pofc_pkg
`default_nettype wire

//--- logic/pofc_gen.sv
// One period generator: down counter with pending period and zero pulse.
`timescale 1ns/1ps
`default_nettype none
module pofc_gen #(
   parameter int CNT_W = 16
) (
   input wire logic clock_in,
   input wire logic srst_in,
   input wire logic period_wr_in,
   input wire logic [CNT_W-1:0] period_in,
   input wire logic run_in,
   output logic zero_out,
   output logic [CNT_W-1:0] count_out,
   output logic [CNT_W-1:0] period_prog_out
);
   logic [CNT_W-1:0] active_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] pend_q;
   logic zero_q;
   wire at_end = (count_q == '0);

   // A pending write replaces any older pending value; it lands at the next zero.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pend_q <= CNT_W'(pofc_pkg::PERIOD_RST);
         active_q <= CNT_W'(pofc_pkg::PERIOD_RST);
         count_q <= '0;
         zero_q <= 1'b0;
      end else begin
         if (period_wr_in) begin
            pend_q <= period_in; // RULE_02
         end
         zero_q <= run_in && at_end;
         if (run_in) begin
            if (at_end) begin
               active_q <= period_wr_in ? period_in : pend_q;
               count_q <= (period_wr_in ? period_in : pend_q) - 1'b1; // RULE_01
            end else begin
               count_q <= count_q - 1'b1;
            end
         end
      end
   end

   assign zero_out = zero_q;
   assign count_out = count_q;
   assign period_prog_out = pend_q;
endmodule : pofc_gen
`default_nettype wire

//--- dv/pofc_stage.sv
// Power stage model that times the period of output 0.
`timescale 1ns/1ps
`default_nettype none
module pofc_stage (
   input wire logic clock_in,
   input wire logic [7:0] pwm_in,
   output logic [15:0] period_out
);
   logic [15:0] run_q;
   logic last_q;
   logic rise;
   // A gate turn-on is a low to high step of the drive line.
   assign rise = pwm_in[0] && !last_q;
   // Counts cycles between turn-ons and keeps the last full period.
   always_ff @(posedge clock_in) begin
      last_q <= pwm_in[0];
      run_q <= rise ? 16'h0001 : run_q + 16'h0001;
      if (rise) begin
         period_out <= run_q;
      end
   end
endmodule : pofc_stage
`default_nettype wire

//--- dv/pofc_top_tb.sv
// Self-checking bench for the modulator output and fault control block.
`timescale 1ns/1ps
`default_nettype none
module pofc_top_tb;
   logic clock_in, srst_in, vsel, irq;
   logic [3:0] run, pwr, gev, fpin, arm;
   logic [15:0] per, wid, mode, meas, wrd, prd;
   logic [7:0] wwr, msk, sup, lvl, inv, oen, pwm, st;
   logic [2:0] wsel;
   logic [1:0] psel;
   int miscompares, checked, cycles, h;
   pofc_top uut (.clock_in(clock_in), .srst_in(srst_in), .gen_run_in(run),
      .period_wr_in(pwr), .period_in(per), .width_wr_in(wwr), .width_in(wid),
      .width_sel_in(wsel), .period_sel_in(psel), .gen_event_in(gev),
      .fault_pin_in(fpin), .irq_mask_in(msk), .status_view_select(vsel),
      .suppress_on_fault(sup), .fault_level_high(lvl), .invert_in(inv),
      .output_drive_enable(oen), .enable_mode_in(mode),
      .global_update_arm_cmd(arm), .pwm_out(pwm), .status_out(st),
      .irq_out(irq), .width_rd_out(wrd), .period_rd_out(prd));
   pofc_stage stage (.clock_in(clock_in), .pwm_in(pwm), .period_out(meas));
   // Free-running 250 MHz clock.
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   // Cuts a hung run short.
   always @(posedge clock_in) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         close_out();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : step
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   // Counts the cycles that output o is high over n cycles.
   task automatic highs(input int o, input int n);
      h = 0;
      repeat (n) begin
         step(1);
         h += int'(pwm[o]);
      end
   endtask : highs
   task automatic close_out();
      $display("Checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   // Raw and masked status views and the module interrupt.
   task automatic t_status();
      gev = 4'h5;
      msk = 8'h04;
      step(2);
      chk("raw", {8'h00, st}, 16'h0005);
      chk("irq", {15'h0000, irq}, 16'h0001);
      vsel = 1'b1;
      step(2);
      chk("masked", {8'h00, st}, 16'h0004);
      msk = 8'h02;
      step(2);
      chk("irq masked", {15'h0000, irq}, 16'h0000);
      gev = 4'h0;
      vsel = 1'b0;
   endtask : t_status
   // Two period writes back to back, readback, then a running generator.
   task automatic t_period();
      per = 16'h0014;
      pwr = 4'h1;
      step(1);
      per = 16'h0008;
      step(1);
      pwr = 4'h0;
      wid = 16'h0003;
      wwr = 8'h01;
      step(1);
      wwr = 8'h00;
      step(2);
      chk("period rd", prd, 16'h0008);
      chk("width rd", wrd, 16'h0003);
      psel = 2'h1;
      step(2);
      chk("period gen1", prd, 16'hffff);
      oen = 8'h07;
      inv = 8'h02;
      run = 4'h1;
      step(60);
      chk("period", meas, 16'h0008);
      chk("invert", {15'h0000, pwm[1]}, 16'h0001);
   endtask : t_period
   // Fault forcing of a suppressed output against a free one.
   task automatic t_fault();
      inv = 8'h04;
      sup = 8'h01;
      lvl = 8'h03;
      fpin = 4'h2;
      step(5);
      chk("fault raw", {8'h00, st}, 16'h0020);
      highs(0, 16);
      chk("fault high", 16'(h), 16'h0010);
      chk("free out", {15'h0000, pwm[1]}, 16'h0000);
      chk("free out2", {15'h0000, pwm[2]}, 16'h0001);
      lvl = 8'h02;
      step(3);
      highs(0, 16);
      chk("fault low", 16'(h), 16'h0000);
      fpin = 4'h0;
      step(5);
      highs(0, 16);
      chk("after fault", 16'(h), 16'h0006);
   endtask : t_fault
   // Global, local and immediate enable updates.
   task automatic t_enable();
      mode = 16'h0002;
      oen = 8'h00;
      step(20);
      highs(0, 16);
      chk("unarmed", 16'(h), 16'h0006);
      arm = 4'h1;
      step(1);
      arm = 4'h0;
      step(10);
      highs(0, 16);
      chk("armed", 16'(h), 16'h0000);
      mode = 16'h0001;
      oen = 8'h01;
      step(12);
      highs(0, 16);
      chk("local", 16'(h), 16'h0006);
      mode = 16'h0003;
      oen = 8'h00;
      step(12);
      highs(0, 16);
      chk("hold", 16'(h), 16'h0006);
      mode = 16'h0000;
      oen = 8'h00;
      step(3);
      highs(0, 16);
      chk("immediate", 16'(h), 16'h0000);
   endtask : t_enable
   // Reset, then the scenarios in turn.
   initial begin
      {run, pwr, gev, fpin, arm, per, wid, mode} = '0;
      {wwr, msk, sup, lvl, inv, oen, wsel, psel, vsel} = '0;
      miscompares = 0;
      checked = 0;
      cycles = 0;
      srst_in = 1'b1;
      step(20);
      srst_in = 1'b0;
      t_status();
      t_period();
      t_fault();
      t_enable();
      close_out();
   end
endmodule : pofc_top_tb
`default_nettype wire
